// ---- hdl/pcicf_pkg.sv ----
`default_nettype none
package pcicf_pkg;
  // bus commands seen in the address phase
  localparam logic [3:0] PCICF_CMD_SPECIAL = 4'h1;
  localparam logic [3:0] PCICF_CMD_CFG_RD = 4'hA;
  localparam logic [3:0] PCICF_CMD_CFG_WR = 4'hB;
  // address type codes in the two lowest bits
  localparam logic [1:0] PCICF_TYPE0 = 2'h0;
  localparam logic [1:0] PCICF_TYPE1 = 2'h1;
  // field positions of a configuration address
  localparam int PCICF_BUS_MSB = 23;
  localparam int PCICF_BUS_LSB = 16;
  localparam int PCICF_DEV_MSB = 15;
  localparam int PCICF_DEV_LSB = 11;
  localparam int PCICF_FN_MSB = 10;
  localparam int PCICF_FN_LSB = 8;
  localparam int PCICF_REG_MSB = 7;
  localparam int PCICF_REG_LSB = 2;
  // broadcast device/function and message register of a special cycle request
  localparam logic [4:0] PCICF_DEV_ALL = 5'h1F;
  localparam logic [2:0] PCICF_FN_ALL = 3'h7;
  localparam logic [5:0] PCICF_REG_MSG = 6'h00;
  // device numbers that own a secondary IDSEL line, own config space functions and full byte enable
  localparam logic [4:0] PCICF_DEV_IDSEL_MAX = 5'h0F;
  localparam logic [2:0] PCICF_FN_PORT_A = 3'h0;
  localparam logic [2:0] PCICF_FN_PORT_B = 3'h1;
  localparam logic [3:0] PCICF_BE_ALL = 4'hF;
  // source and target port numbering
  localparam logic [1:0] PCICF_PORT_UP = 2'h0;
  localparam logic [1:0] PCICF_PORT_A = 2'h1;
  localparam logic [1:0] PCICF_PORT_B = 2'h2;
  localparam int PCICF_NSRC = 3;

  typedef enum logic [2:0] {
    PCICF_ACT_NONE = 3'b000,
    PCICF_ACT_OWN = 3'b001,
    PCICF_ACT_CONV = 3'b010,
    PCICF_ACT_FWD_DN = 3'b011,
    PCICF_ACT_FWD_UP = 3'b100,
    PCICF_ACT_SPECIAL = 3'b101
  } pcicf_act_t;

  typedef enum logic [1:0] {
    PCICF_SLOT_IDLE = 2'b00,
    PCICF_SLOT_ISSUE = 2'b01,
    PCICF_SLOT_WAIT = 2'b10,
    PCICF_SLOT_READY = 2'b11
  } pcicf_slot_t;
endpackage
`default_nettype wire

// ---- hdl/pcicf_decode.sv ----
`default_nettype none
module pcicf_decode (
  input wire logic [1:0] src,
  input wire logic [31:0] addr,
  input wire logic [3:0] cmd,
  input wire logic idsel,
  input wire logic [7:0] prim_bus,
  input wire logic [7:0] sec_a,
  input wire logic [7:0] sub_a,
  input wire logic [7:0] sec_b,
  input wire logic [7:0] sub_b,
  output pcicf_pkg::pcicf_act_t act,
  output logic [1:0] tgt,
  output logic [31:0] out_addr,
  output logic [3:0] out_cmd
);
  import pcicf_pkg::*;

  // one-hot secondary IDSEL pattern; devices above 15 get none
  function automatic logic [15:0] idsel_of(input logic [4:0] dev);
    logic [15:0] hot;
    hot = 16'h0001 << dev[3:0];
    return (dev > PCICF_DEV_IDSEL_MAX) ? 16'h0000 : hot;
  endfunction

  logic [7:0] bus;
  logic [4:0] dev;
  logic [2:0] fn;
  logic [5:0] regn;
  logic is_cfg;
  logic is_wr;
  logic bcast;
  logic [7:0] own_sec;
  logic [7:0] own_sub;

  assign bus = addr[PCICF_BUS_MSB:PCICF_BUS_LSB];
  assign dev = addr[PCICF_DEV_MSB:PCICF_DEV_LSB];
  assign fn = addr[PCICF_FN_MSB:PCICF_FN_LSB];
  assign regn = addr[PCICF_REG_MSB:PCICF_REG_LSB];
  assign is_wr = (cmd == PCICF_CMD_CFG_WR);
  assign is_cfg = is_wr || (cmd == PCICF_CMD_CFG_RD); // received special cycles never claim
  assign bcast = is_wr && (dev == PCICF_DEV_ALL) && (fn == PCICF_FN_ALL);
  assign own_sec = (src == PCICF_PORT_B) ? sec_b : sec_a;
  assign own_sub = (src == PCICF_PORT_B) ? sub_b : sub_a;

  // special cycle requests are checked ahead of conversion so a write to device 1fh function 7 reg 0 never converts
  always_comb begin
    act = PCICF_ACT_NONE;
    tgt = PCICF_PORT_UP;
    if (src == PCICF_PORT_UP) begin
      if (is_cfg && addr[1:0] == PCICF_TYPE0 && idsel) begin
        act = PCICF_ACT_OWN;
      end else if (is_cfg && addr[1:0] == PCICF_TYPE1) begin
        if (bcast && regn == PCICF_REG_MSG && (bus == sec_a || bus == sec_b)) begin
          act = PCICF_ACT_SPECIAL;
          tgt = (bus == sec_a) ? PCICF_PORT_A : PCICF_PORT_B;
        end else if (bus == sec_a || bus == sec_b) begin
          act = PCICF_ACT_CONV;
          tgt = (bus == sec_a) ? PCICF_PORT_A : PCICF_PORT_B;
        end else if ((bus > sec_a && bus <= sub_a) || (bus > sec_b && bus <= sub_b)) begin
          act = PCICF_ACT_FWD_DN;
          tgt = (bus > sec_a && bus <= sub_a) ? PCICF_PORT_A : PCICF_PORT_B;
        end
      end
    end else if (bcast && addr[1:0] == PCICF_TYPE1) begin
      // type 0 from a secondary side never lands here, so it goes unclaimed
      if (regn == PCICF_REG_MSG && bus == prim_bus) begin
        act = PCICF_ACT_SPECIAL;
      end else if (bus < own_sec || bus > own_sub) begin
        act = PCICF_ACT_FWD_UP;
      end
    end
  end

  // address and command as driven on the target bus
  always_comb begin
    out_addr = addr;
    out_cmd = cmd;
    if (act == PCICF_ACT_CONV) begin
      out_addr = {idsel_of(dev), 5'h00, addr[10:2], PCICF_TYPE0};
    end
    if (act == PCICF_ACT_SPECIAL) begin
      out_cmd = PCICF_CMD_SPECIAL;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/pcicf_bridge.sv ----
`default_nettype none
module pcicf_bridge (
  input wire logic clk,
  input wire logic rst,
  input wire logic upstream_port_addr_valid,
  input wire logic [31:0] upstream_port_addr_data,
  input wire logic [3:0] upstream_port_command_byte_enable,
  input wire logic [3:0] upstream_port_data_byte_enable,
  input wire logic upstream_port_config_select,
  input wire logic upstream_port_more_data,
  input wire logic downstream_port_a_addr_valid,
  input wire logic [31:0] downstream_port_a_addr_data,
  input wire logic [3:0] downstream_port_a_command,
  input wire logic downstream_port_a_more_data,
  input wire logic downstream_port_b_addr_valid,
  input wire logic [31:0] downstream_port_b_addr_data,
  input wire logic [3:0] downstream_port_b_command,
  input wire logic downstream_port_b_more_data,
  input wire logic [7:0] primary_bus_number,
  input wire logic [7:0] port_a_secondary_bus_number,
  input wire logic [7:0] port_a_subordinate_bus_number,
  input wire logic [7:0] port_b_secondary_bus_number,
  input wire logic [7:0] port_b_subordinate_bus_number,
  input wire logic fwd_ack,
  input wire logic fwd_done,
  input wire logic fwd_master_abort,
  output logic upstream_port_device_select_n,
  output logic upstream_port_target_ready_n,
  output logic upstream_port_stop_n,
  output logic downstream_port_a_device_select_n,
  output logic downstream_port_a_target_ready_n,
  output logic downstream_port_a_stop_n,
  output logic downstream_port_b_device_select_n,
  output logic downstream_port_b_target_ready_n,
  output logic downstream_port_b_stop_n,
  output logic own_cfg_strobe,
  output logic own_cfg_write,
  output logic own_cfg_space_b,
  output logic [5:0] own_cfg_register,
  output logic [3:0] own_cfg_byte_enable,
  output logic fwd_valid,
  output logic [1:0] fwd_port,
  output logic [31:0] fwd_addr,
  output logic [3:0] fwd_cmd
);
  import pcicf_pkg::*;

  // sources gathered into arrays: 0 upstream port, 1 port a, 2 port b
  logic in_valid [PCICF_NSRC];
  logic [31:0] in_addr [PCICF_NSRC];
  logic [3:0] in_cmd [PCICF_NSRC];
  logic in_more [PCICF_NSRC];
  pcicf_act_t dec_act [PCICF_NSRC];
  logic [1:0] dec_tgt [PCICF_NSRC];
  logic [31:0] dec_addr [PCICF_NSRC];
  logic [3:0] dec_cmd [PCICF_NSRC];

  assign in_valid[0] = upstream_port_addr_valid;
  assign in_valid[1] = downstream_port_a_addr_valid;
  assign in_valid[2] = downstream_port_b_addr_valid;
  assign in_addr[0] = upstream_port_addr_data;
  assign in_addr[1] = downstream_port_a_addr_data;
  assign in_addr[2] = downstream_port_b_addr_data;
  assign in_cmd[0] = upstream_port_command_byte_enable;
  assign in_cmd[1] = downstream_port_a_command;
  assign in_cmd[2] = downstream_port_b_command;
  assign in_more[0] = upstream_port_more_data;
  assign in_more[1] = downstream_port_a_more_data;
  assign in_more[2] = downstream_port_b_more_data;

  // one decoder per bus; idsel only exists on the upstream side
  for (genvar i = 0; i < PCICF_NSRC; i++) begin : g_dec
    pcicf_decode u_dec (
      .src(2'(i)),
      .addr(in_addr[i]),
      .cmd(in_cmd[i]),
      .idsel((i == 0) ? upstream_port_config_select : 1'b0),
      .prim_bus(primary_bus_number),
      .sec_a(port_a_secondary_bus_number),
      .sub_a(port_a_subordinate_bus_number),
      .sec_b(port_b_secondary_bus_number),
      .sub_b(port_b_subordinate_bus_number),
      .act(dec_act[i]),
      .tgt(dec_tgt[i]),
      .out_addr(dec_addr[i]),
      .out_cmd(dec_cmd[i])
    );
  end

  // single delayed transaction slot; a second request simply keeps getting retried
  pcicf_slot_t slot_reg;
  pcicf_slot_t slot_next;
  logic [1:0] slot_src_reg;
  logic [31:0] slot_addr_reg;
  logic [3:0] slot_cmd_reg;
  pcicf_act_t slot_act_reg;
  logic slot_mabort_reg;

  logic devsel_n_next [PCICF_NSRC];
  logic trdy_n_next [PCICF_NSRC];
  logic stop_n_next [PCICF_NSRC];
  logic devsel_n_reg [PCICF_NSRC];
  logic trdy_n_reg [PCICF_NSRC];
  logic stop_n_reg [PCICF_NSRC];
  logic capture;
  logic [1:0] capture_src;
  logic release_slot;
  logic match [PCICF_NSRC];

  // a repeat matches only when it is the very same address and command
  always_comb begin
    for (int i = 0; i < PCICF_NSRC; i++) begin
      match[i] = (slot_reg != PCICF_SLOT_IDLE) && (slot_src_reg == 2'(i)) &&
                 (slot_addr_reg == in_addr[i]) && (slot_cmd_reg == in_cmd[i]);
    end
  end

  // target response per bus, decided in the address phase
  always_comb begin
    capture = 1'b0;
    capture_src = PCICF_PORT_UP;
    release_slot = 1'b0;
    for (int i = 0; i < PCICF_NSRC; i++) begin
      devsel_n_next[i] = 1'b1;
      trdy_n_next[i] = 1'b1;
      stop_n_next[i] = 1'b1;
      if (in_valid[i] && dec_act[i] == PCICF_ACT_OWN) begin
        devsel_n_next[i] = 1'b0;
        trdy_n_next[i] = 1'b0;
        stop_n_next[i] = !in_more[i];
      end else if (in_valid[i] && dec_act[i] != PCICF_ACT_NONE) begin
        if (match[i] && slot_reg == PCICF_SLOT_READY) begin
          release_slot = 1'b1;
          // a master abort is passed back by not claiming, except for special cycles
          if (!slot_mabort_reg || slot_act_reg == PCICF_ACT_SPECIAL) begin
            devsel_n_next[i] = 1'b0;
            trdy_n_next[i] = 1'b0;
            stop_n_next[i] = !in_more[i];
          end
        end else begin
          devsel_n_next[i] = 1'b0; // retry until the target bus is done
          stop_n_next[i] = 1'b0;
          if (!match[i] && slot_reg == PCICF_SLOT_IDLE && !capture) begin
            capture = 1'b1; // lowest source number wins the free slot
            capture_src = 2'(i);
          end
        end
      end
    end
  end

  // slot sequencing: issue to target bus, wait for its end, wait for the repeat
  always_comb begin
    slot_next = slot_reg;
    case (slot_reg)
      PCICF_SLOT_IDLE: begin
        if (capture) begin
          slot_next = PCICF_SLOT_ISSUE;
        end
      end
      PCICF_SLOT_ISSUE: begin
        if (fwd_ack) begin
          slot_next = PCICF_SLOT_WAIT;
        end
      end
      PCICF_SLOT_WAIT: begin
        if (fwd_done) begin
          slot_next = PCICF_SLOT_READY;
        end
      end
      PCICF_SLOT_READY: begin
        if (release_slot) begin
          slot_next = PCICF_SLOT_IDLE;
        end
      end
      default: begin
        slot_next = PCICF_SLOT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_reg <= PCICF_SLOT_IDLE;
    end else begin
      slot_reg <= slot_next;
    end
  end

  // captured request; original address kept for matching, translated one for issue
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_src_reg <= PCICF_PORT_UP;
      slot_addr_reg <= 32'h0000_0000;
      slot_cmd_reg <= 4'h0;
      slot_act_reg <= PCICF_ACT_NONE;
    end else if (capture) begin
      slot_src_reg <= capture_src;
      slot_addr_reg <= in_addr[capture_src];
      slot_cmd_reg <= in_cmd[capture_src];
      slot_act_reg <= dec_act[capture_src];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      slot_mabort_reg <= 1'b0;
    end else if (capture) begin
      slot_mabort_reg <= 1'b0;
    end else if (slot_reg == PCICF_SLOT_WAIT && fwd_done) begin
      slot_mabort_reg <= fwd_master_abort;
    end
  end

  // target bus request; held from capture until the master side takes it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fwd_valid <= 1'b0;
      fwd_port <= PCICF_PORT_UP;
      fwd_addr <= 32'h0000_0000;
      fwd_cmd <= 4'h0;
    end else if (capture) begin
      fwd_valid <= 1'b1;
      fwd_port <= dec_tgt[capture_src];
      fwd_addr <= dec_addr[capture_src];
      fwd_cmd <= dec_cmd[capture_src];
    end else if (fwd_ack) begin
      fwd_valid <= 1'b0;
    end
  end

  // target response outputs, one cycle after the address phase
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < PCICF_NSRC; i++) begin
        devsel_n_reg[i] <= 1'b1;
        trdy_n_reg[i] <= 1'b1;
        stop_n_reg[i] <= 1'b1;
      end
    end else begin
      for (int i = 0; i < PCICF_NSRC; i++) begin
        devsel_n_reg[i] <= devsel_n_next[i];
        trdy_n_reg[i] <= trdy_n_next[i];
        stop_n_reg[i] <= stop_n_next[i];
      end
    end
  end

  assign upstream_port_device_select_n = devsel_n_reg[0];
  assign upstream_port_target_ready_n = trdy_n_reg[0];
  assign upstream_port_stop_n = stop_n_reg[0];
  assign downstream_port_a_device_select_n = devsel_n_reg[1];
  assign downstream_port_a_target_ready_n = trdy_n_reg[1];
  assign downstream_port_a_stop_n = stop_n_reg[1];
  assign downstream_port_b_device_select_n = devsel_n_reg[2];
  assign downstream_port_b_target_ready_n = trdy_n_reg[2];
  assign downstream_port_b_stop_n = stop_n_reg[2];

  // own register file strobe; functions above 1 are claimed but touch nothing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      own_cfg_strobe <= 1'b0;
      own_cfg_write <= 1'b0;
      own_cfg_space_b <= 1'b0;
      own_cfg_register <= 6'h00;
      own_cfg_byte_enable <= 4'h0;
    end else begin
      own_cfg_strobe <= in_valid[0] && dec_act[0] == PCICF_ACT_OWN &&
        in_addr[0][PCICF_FN_MSB:PCICF_FN_LSB] <= PCICF_FN_PORT_B;
      own_cfg_write <= (in_cmd[0] == PCICF_CMD_CFG_WR);
      own_cfg_space_b <= (in_addr[0][PCICF_FN_MSB:PCICF_FN_LSB] == PCICF_FN_PORT_B);
      own_cfg_register <= in_addr[0][PCICF_REG_MSB:PCICF_REG_LSB];
      // reads have no side effects, so the whole dword is always fetched
      own_cfg_byte_enable <= (in_cmd[0] == PCICF_CMD_CFG_WR) ?
        upstream_port_data_byte_enable : PCICF_BE_ALL;
    end
  end

  // checks on the decode and slot behaviour
  sequence s_own_hit;
    upstream_port_addr_valid && dec_act[0] == PCICF_ACT_OWN;
  endsequence

  sequence s_capture;
    capture && slot_reg == PCICF_SLOT_IDLE;
  endsequence

  a_own_claim_now: assert property (@(posedge clk) disable iff (rst)
    s_own_hit |=> !upstream_port_device_select_n && !upstream_port_target_ready_n)
    else $error("own config access not claimed at once");

  a_own_one_dword: assert property (@(posedge clk) disable iff (rst)
    s_own_hit ##0 upstream_port_more_data |=> !upstream_port_stop_n)
    else $error("own burst access not disconnected");

  a_read_all_bytes: assert property (@(posedge clk) disable iff (rst)
    s_own_hit ##0 upstream_port_command_byte_enable == PCICF_CMD_CFG_RD
    |=> own_cfg_byte_enable == PCICF_BE_ALL)
    else $error("own read did not enable all bytes");

  a_sec_type0_ignored: assert property (@(posedge clk) disable iff (rst)
    downstream_port_a_addr_valid && downstream_port_a_addr_data[1:0] == PCICF_TYPE0
    |=> downstream_port_a_device_select_n)
    else $error("type 0 on a secondary port was claimed");

  a_miss_unclaimed: assert property (@(posedge clk) disable iff (rst)
    upstream_port_addr_valid && dec_act[0] == PCICF_ACT_NONE |=> upstream_port_device_select_n)
    else $error("unmatched upstream access was claimed");

  a_first_try_retry: assert property (@(posedge clk) disable iff (rst)
    s_capture |=> (fwd_valid && slot_reg == PCICF_SLOT_ISSUE)
    ##0 (!devsel_n_reg[slot_src_reg] && trdy_n_reg[slot_src_reg]
    && !stop_n_reg[slot_src_reg]))
    else $error("new delayed request not retried and issued");

  a_conv_address: assert property (@(posedge clk) disable iff (rst)
    s_capture ##0 dec_act[capture_src] == PCICF_ACT_CONV
    |=> fwd_addr[1:0] == PCICF_TYPE0 && fwd_addr[15:11] == 5'h00
    && $onehot0(fwd_addr[31:16]))
    else $error("converted address malformed");

  a_no_type0_up: assert property (@(posedge clk) disable iff (rst)
    fwd_valid && fwd_port == PCICF_PORT_UP |-> fwd_addr[1:0] == PCICF_TYPE1)
    else $error("type 0 issued toward the upstream port");

  a_special_command: assert property (@(posedge clk) disable iff (rst)
    fwd_valid && slot_act_reg == PCICF_ACT_SPECIAL |-> fwd_cmd == PCICF_CMD_SPECIAL
    && fwd_addr == slot_addr_reg)
    else $error("special cycle command or address wrong");

  a_special_done_trdy: assert property (@(posedge clk) disable iff (rst)
    slot_reg == PCICF_SLOT_READY && slot_act_reg == PCICF_ACT_SPECIAL
    && in_valid[slot_src_reg] && match[slot_src_reg]
    |=> slot_reg == PCICF_SLOT_IDLE && !trdy_n_reg[slot_src_reg])
    else $error("completed special cycle repeat not answered with trdy");
endmodule
`default_nettype wire

// ---- verif/pcicf_far_model.sv ----
`default_nettype none
module pcicf_far_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic fwd_valid,
  input wire logic slow,
  input wire logic abort,
  output logic fwd_ack,
  output logic fwd_done,
  output logic fwd_master_abort
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_reg;
  logic busy_reg;
  // takes the request at once, or after a wait when slow, then ends it on the target bus later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 4'h0;
      busy_reg <= 1'b0;
      fwd_ack <= 1'b0;
      fwd_done <= 1'b0;
      fwd_master_abort <= 1'b0;
    end else begin
      fwd_ack <= 1'b0;
      fwd_done <= 1'b0;
      // wrong level outside done so an unqualified read shows up
      fwd_master_abort <= ~abort;
      cnt_reg <= cnt_reg + 4'h1;
      if (fwd_valid && !busy_reg && !fwd_ack) begin
        if (cnt_reg >= (slow ? 4'h5 : 4'h0)) begin
          fwd_ack <= 1'b1;
          busy_reg <= 1'b1;
          cnt_reg <= 4'h0;
        end
      end else if (busy_reg && cnt_reg == (slow ? 4'h9 : 4'h2)) begin
        fwd_done <= 1'b1;
        fwd_master_abort <= abort;
        busy_reg <= 1'b0;
      end else if (!busy_reg) begin
        cnt_reg <= 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/pcicf_bridge_tb.sv ----
`default_nettype none
module pcicf_bridge_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pcicf_pkg::*;
  localparam logic [7:0] PB = 8'h01, SA = 8'h02, UA = 8'h05, SB = 8'h06, UB = 8'h09;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] av = 3'h0;
  logic [31:0] ad [3] = '{default: '0};
  logic [3:0] cm [3] = '{default: '0};
  logic [2:0] md = 3'h0;
  logic isel = 1'b0;
  logic [3:0] dbe = 4'h0;
  logic slow = 1'b0;
  logic abort = 1'b0;
  int fail_count = 0;
  int total_checks = 0;
  wire logic [2:0] ds_n, tr_n, st_n;
  wire logic ack, done, mab, stb, wr, spb, fv;
  wire logic [5:0] rg;
  wire logic [3:0] be, fc;
  wire logic [1:0] fp;
  wire logic [31:0] fa;
  pcicf_bridge i_dut (.clk(clk), .rst(rst), .upstream_port_addr_valid(av[0]),
    .upstream_port_addr_data(ad[0]), .upstream_port_command_byte_enable(cm[0]),
    .upstream_port_data_byte_enable(dbe), .upstream_port_config_select(isel),
    .upstream_port_more_data(md[0]), .downstream_port_a_addr_valid(av[1]),
    .downstream_port_a_addr_data(ad[1]), .downstream_port_a_command(cm[1]),
    .downstream_port_a_more_data(md[1]), .downstream_port_b_addr_valid(av[2]),
    .downstream_port_b_addr_data(ad[2]), .downstream_port_b_command(cm[2]),
    .downstream_port_b_more_data(md[2]), .primary_bus_number(PB),
    .port_a_secondary_bus_number(SA), .port_a_subordinate_bus_number(UA),
    .port_b_secondary_bus_number(SB), .port_b_subordinate_bus_number(UB),
    .fwd_ack(ack), .fwd_done(done), .fwd_master_abort(mab),
    .upstream_port_device_select_n(ds_n[0]), .upstream_port_target_ready_n(tr_n[0]),
    .upstream_port_stop_n(st_n[0]), .downstream_port_a_device_select_n(ds_n[1]),
    .downstream_port_a_target_ready_n(tr_n[1]), .downstream_port_a_stop_n(st_n[1]),
    .downstream_port_b_device_select_n(ds_n[2]), .downstream_port_b_target_ready_n(tr_n[2]),
    .downstream_port_b_stop_n(st_n[2]), .own_cfg_strobe(stb), .own_cfg_write(wr),
    .own_cfg_space_b(spb), .own_cfg_register(rg), .own_cfg_byte_enable(be),
    .fwd_valid(fv), .fwd_port(fp), .fwd_addr(fa), .fwd_cmd(fc));
  pcicf_far_model i_far (.clk(clk), .rst(rst), .fwd_valid(fv), .slow(slow), .abort(abort),
    .fwd_ack(ack), .fwd_done(done), .fwd_master_abort(mab));
  // clock, and a watchdog far beyond the few hundred cycles the run needs
  always #5 clk = ~clk;
  initial begin
    #100000;
    fail_count++;
    end_sim();
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [31:0] cfg1(input logic [7:0] b, input logic [4:0] d,
      input logic [2:0] f, input logic [5:0] r);
    return {8'h00, b, d, f, r, 2'h1};
  endfunction
  // raises an address phase on bus p; held until rsp releases it
  task automatic acc(input int p, input logic [31:0] a, input logic [3:0] c, input logic m);
    av[p] = 1'b1;
    ad[p] = a;
    cm[p] = c;
    md[p] = m;
    @(posedge clk);
    #1;
  endtask
  // response stands one cycle, so it is judged here before release
  task automatic rsp(input int p, input logic d, input logic t, input logic s);
    chk("devsel_n", ds_n[p], d);
    chk("trdy_n", tr_n[p], t);
    chk("stop_n", st_n[p], s);
    av[p] = 1'b0;
    @(posedge clk);
    #1;
  endtask
  // delayed path: retry and capture, retry while busy, finish on repeat
  task automatic dly(input int p, input logic [31:0] a, input logic [3:0] c,
      input logic [1:0] ep, input logic [31:0] ea, input logic [3:0] ec, input logic ok);
    int n;
    acc(p, a, c, 1'b0);
    chk("fwd_valid", fv, 1'b1);
    chk("fwd_port", fp, ep);
    chk("fwd_addr", fa, ea);
    chk("fwd_cmd", fc, ec);
    rsp(p, 1'b0, 1'b1, 1'b0);
    acc(p, a, c, 1'b0);
    rsp(p, 1'b0, 1'b1, 1'b0);
    for (n = 0; n < 40 && done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    chk("fwd_done", done, 1'b1);
    @(posedge clk);
    #1;
    acc(p, a, c, 1'b1);
    rsp(p, ~ok, ~ok, ~ok);
  endtask
  // own space: read asking more data, write to function 1, idsel low
  task automatic t_own();
    isel = 1'b1;
    dbe = 4'h2;
    acc(0, 32'h0000_0024, PCICF_CMD_CFG_RD, 1'b1);
    chk("strobe", stb, 1'b1);
    chk("space_b", spb, 1'b0);
    chk("register", rg, 6'h09);
    chk("byte_en", be, PCICF_BE_ALL);
    rsp(0, 1'b0, 1'b0, 1'b0);
    acc(0, 32'h0000_0130, PCICF_CMD_CFG_WR, 1'b0);
    chk("write", wr, 1'b1);
    chk("space_b", spb, 1'b1);
    chk("byte_en", be, 4'h2);
    rsp(0, 1'b0, 1'b0, 1'b1);
    acc(0, 32'h0000_0224, PCICF_CMD_CFG_RD, 1'b0);
    chk("strobe", stb, 1'b0);
    rsp(0, 1'b0, 1'b0, 1'b1);
    isel = 1'b0;
    acc(0, 32'h0000_0024, PCICF_CMD_CFG_RD, 1'b0);
    chk("strobe", stb, 1'b0);
    rsp(0, 1'b1, 1'b1, 1'b1);
  endtask
  // requests that must stay unclaimed
  task automatic t_refuse();
    int p;
    for (p = 1; p < 3; p++) begin
      acc(p, 32'h0000_0000, PCICF_CMD_CFG_RD, 1'b0);
      rsp(p, 1'b1, 1'b1, 1'b1);
    end
    acc(0, 32'h0000_0000, PCICF_CMD_SPECIAL, 1'b0);
    chk("fwd_valid", fv, 1'b0);
    rsp(0, 1'b1, 1'b1, 1'b1);
    acc(0, cfg1(8'hF0, 5'h01, 3'h0, 6'h00), PCICF_CMD_CFG_RD, 1'b0);
    rsp(0, 1'b1, 1'b1, 1'b1);
    acc(1, cfg1(SA, PCICF_DEV_ALL, PCICF_FN_ALL, 6'h03), PCICF_CMD_CFG_WR, 1'b0);
    rsp(1, 1'b1, 1'b1, 1'b1);
  endtask
  // conversion over device numbers 0 to 16, both ports, then forwards and special cycles
  task automatic t_dly();
    int d;
    logic [31:0] a;
    for (d = 0; d < 17; d++) begin
      a = cfg1(d[1] ? SB : SA, d[4:0], 3'h2, 6'h05);
      slow = d[0];
      abort = (d == 16);
      dly(0, a, d[2] ? PCICF_CMD_CFG_WR : PCICF_CMD_CFG_RD, d[1] ? PCICF_PORT_B : PCICF_PORT_A,
        {(d < 16) ? 16'h0001 << d : 16'h0000, 5'h00, a[10:2], 2'h0},
        d[2] ? PCICF_CMD_CFG_WR : PCICF_CMD_CFG_RD, ~abort);
    end
    abort = 1'b0;
    a = cfg1(UA, 5'h04, 3'h1, 6'h02);
    dly(0, a, PCICF_CMD_CFG_RD, PCICF_PORT_A, a, PCICF_CMD_CFG_RD, 1'b1);
    a = cfg1(SB + 8'h01, 5'h04, 3'h1, 6'h02);
    dly(0, a, PCICF_CMD_CFG_WR, PCICF_PORT_B, a, PCICF_CMD_CFG_WR, 1'b1);
    a = cfg1(8'h20, PCICF_DEV_ALL, PCICF_FN_ALL, 6'h03);
    dly(2, a, PCICF_CMD_CFG_WR, PCICF_PORT_UP, a, PCICF_CMD_CFG_WR, 1'b1);
    abort = 1'b1;
    a = cfg1(SB, PCICF_DEV_ALL, PCICF_FN_ALL, PCICF_REG_MSG);
    dly(0, a, PCICF_CMD_CFG_WR, PCICF_PORT_B, a, PCICF_CMD_SPECIAL, 1'b1);
    a = cfg1(PB, PCICF_DEV_ALL, PCICF_FN_ALL, PCICF_REG_MSG);
    dly(1, a, PCICF_CMD_CFG_WR, PCICF_PORT_UP, a, PCICF_CMD_SPECIAL, 1'b1);
  endtask
  // reset for 16 cycles, inputs then move 1 ns after each rising edge
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("devsel_n", ds_n, 3'h7);
    chk("fwd_valid", fv, 1'b0);
    t_own();
    t_refuse();
    t_dly();
    end_sim();
  end
endmodule
`default_nettype wire
